// ### src/bfr_channel.v
// One regulator channel: switch sequencing, current limits, hiccup, soft start.
// Assumes synchronised comparator levels and a one-cycle oscillator pulse.
`timescale 1ns/10ps
`include "bfr_regs.vh"
module bfr_channel (
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  input  wire        i_run,
  input  wire        i_osc_tick,
  input  wire        i_peak_lim,
  input  wire        i_src_lim,
  input  wire        i_sink_lim,
  output reg         o_hs_on,
  output reg         o_ls_on,
  output reg         o_ss_busy,
  output reg         o_hiccup
);
  localparam ST_OFF  = 2'h0;
  localparam ST_SOFT = 2'h1;
  localparam ST_REG  = 2'h2;
  localparam ST_HIC  = 2'h3;

  reg [1:0]  st_q;
  reg [12:0] cnt_q;
  reg [3:0]  oc_q;
  reg        peak_seen_q;
  wire       active = (st_q == ST_SOFT) || (st_q == ST_REG);
  // Peak events count mid-cycle, so the count may already stand at the trip
  wire       oc_hit = (oc_q >= `BFR_OC_TRIP) ||
                      ((oc_q == `BFR_OC_TRIP - 4'h1) && i_src_lim);

  // State, counters and gate commands move together so they cannot disagree
  always @(posedge i_core_clk) begin
    if (!i_rst_n || !i_run) begin
      st_q <= ST_OFF;
      cnt_q <= 13'h0000;
      oc_q <= 4'h0;
      peak_seen_q <= 1'b0;
      o_hs_on <= 1'b0;
      o_ls_on <= 1'b0;
      o_ss_busy <= 1'b0;
      o_hiccup <= 1'b0;
    end else begin
      case (st_q)
        ST_OFF: begin
          st_q <= ST_SOFT;
          cnt_q <= 13'h0000;
          o_ss_busy <= 1'b1;
        end
        ST_SOFT: begin
          if (i_osc_tick) begin
            cnt_q <= cnt_q + 13'h0001;
            if (cnt_q == {1'b0, `BFR_SS_CYCLES} - 13'h0001) begin
              st_q <= ST_REG;
              o_ss_busy <= 1'b0;
            end
          end
        end
        ST_REG: ;
        ST_HIC: begin
          o_hs_on <= 1'b0;
          o_ls_on <= 1'b0;
          // Exit only on a tick so the full count of cycles is spent off
          if (i_osc_tick) begin
            if (cnt_q == `BFR_HICCUP_CYCLES - 13'h0001) begin
              st_q <= ST_SOFT;
              cnt_q <= 13'h0000;
              o_hiccup <= 1'b0;
              o_ss_busy <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 13'h0001;
            end
          end
        end
        default: st_q <= ST_OFF;
      endcase
      if (active) begin
        if (i_osc_tick) begin
          // Cycle boundary: judge the cycle just ended
          peak_seen_q <= 1'b0;
          if (oc_hit) begin
            st_q <= ST_HIC;
            cnt_q <= 13'h0000;
            o_hiccup <= 1'b1;
            o_ss_busy <= 1'b0;
            oc_q <= 4'h0;
            o_hs_on <= 1'b0;
            o_ls_on <= 1'b0;
          end else if (i_src_lim) begin
            o_hs_on <= 1'b0;
            o_ls_on <= 1'b1;
            oc_q <= oc_q + 4'h1;
          end else begin
            o_hs_on <= 1'b1;
            o_ls_on <= 1'b0;
            if (!peak_seen_q && !i_peak_lim)
              oc_q <= 4'h0;
          end
        end else if (i_sink_lim) begin
          o_hs_on <= 1'b0;
          o_ls_on <= 1'b0;
        end else if (i_peak_lim && o_hs_on) begin
          o_hs_on <= 1'b0;
          o_ls_on <= 1'b1;
          peak_seen_q <= 1'b1;
          oc_q <= oc_q + 4'h1;
        end
      end
    end
  end
endmodule // bfr_channel

// ### src/bfr_regs.vh
// Constants for the buck fault and reset sequencer.
// Assumes inclusion by bare name from the channel and top design files of the block.
// What this block does
// - Each oscillator cycle turns high side on; peak trip swaps to low side.
// - Enable above upper threshold enables both channels.
// - Enable below lower threshold shuts both channels and internal logic down.
// - Startup ramp is a soft start of fixed oscillator cycle count.
// - Peak limit turns high side off, low side on, counts overcurrent.
// - Low-side source over limit at cycle end keeps low side, counts.
// - High side restarts only when low-side source current is below limit.
// - Overcurrent counter clears after a cycle without peak or source limit.
// - Counter reaching ten enters hiccup with both switches off.
// - Hiccup lasts fixed cycles then soft starts again; faults re-enter.
// - Sink limit turns both switches off until next cycle.
// - Reset output is open drain, good status by releasing the line.
// - Output-good detection uses rising and falling thresholds, no chatter.
// - Capacitor mode: release after delay when both good, drop on either.
// - Release delay is longer of internal delay and timer-pin charge.
// - Resistor-capacitor mode also drops reset on watchdog fault fall.
// - Floating timer pin gives fixed internal delay only.
// - Strobe held past timeout drives watchdog fault output low.
`ifndef BFR_REGS_VH
`define BFR_REGS_VH
`define BFR_CLK_MHZ        100
`define BFR_OSC_KHZ        300
// Oscillator period in core cycles, rounded down
`define BFR_OSC_DIV        ((`BFR_CLK_MHZ * 1000) / `BFR_OSC_KHZ)
`define BFR_OSC_W          9
`define BFR_SS_CYCLES      12'h200
`define BFR_HICCUP_CYCLES  13'h1000
`define BFR_OC_TRIP        4'hA
`define BFR_POR_DELAY_US   1700
`define BFR_POR_DELAY_CLK  (`BFR_POR_DELAY_US * `BFR_CLK_MHZ)
`define BFR_WD_TIMEOUT_US  50000
`define BFR_WD_TIMEOUT_CLK (`BFR_WD_TIMEOUT_US * `BFR_CLK_MHZ)
`define BFR_DLY_W          23
`define BFR_WD_W           23
`define BFR_TMR_CAP        2'h0
`define BFR_TMR_RC         2'h1
`define BFR_TMR_FLOAT      2'h2
`endif

// ### src/bfr_sync.v
// Two-flip-flop synchroniser for a bus of asynchronous comparator levels.
// Assumes one core clock; inputs may change at any time.
`timescale 1ns/10ps
module bfr_sync #(
  parameter W = 1
) (
  input  wire         i_core_clk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // bfr_sync

// ### src/bfr_top.v
// Top of the buck fault and reset sequencer: enable, oscillator, two
// channels, output-good hysteresis, reset delay and watchdog.
// Assumes all comparator and pin inputs are asynchronous to i_core_clk.
`timescale 1ns/10ps
`include "bfr_regs.vh"
module bfr_top #(
  parameter [`BFR_DLY_W-1:0] POR_DELAY_CLK = `BFR_POR_DELAY_CLK,
  parameter [`BFR_WD_W-1:0]  WD_TIMEOUT_CLK = `BFR_WD_TIMEOUT_CLK
) (
  input  wire       i_core_clk,
  input  wire       i_rst_n,
  input  wire       i_en_above_hi,
  input  wire       i_en_below_lo,
  input  wire [1:0] i_peak_lim,
  input  wire [1:0] i_src_lim,
  input  wire [1:0] i_sink_lim,
  input  wire [1:0] i_fb_above_rise,
  input  wire [1:0] i_fb_below_fall,
  input  wire [1:0] i_timer_cfg,
  input  wire       i_timer_charged,
  input  wire       i_watchdog_strobe_in,
  output reg  [1:0] o_hs_on,
  output reg  [1:0] o_ls_on,
  output reg        o_enabled,
  output reg        o_por_oe,
  output reg        o_por_out,
  output reg        o_watchdog_fault_oe,
  output reg        o_watchdog_fault_out
);
  localparam SW = 12;

  wire [SW-1:0] s;
  wire [1:0] hs_w;
  wire [1:0] ls_w;
  wire [1:0] ssb_w;
  wire [1:0] hic_w;

  // All comparators cross into the core clock here; timer and strobe pins below
  bfr_sync #(.W(SW)) bfr_sync_inst (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    ({i_en_above_hi, i_en_below_lo, i_peak_lim, i_src_lim,
                  i_sink_lim, i_fb_above_rise, i_fb_below_fall}),
    .o_sync     (s)
  );

  wire       en_hi  = s[11];
  wire       en_lo  = s[10];
  wire [1:0] pk     = s[9:8];
  wire [1:0] src    = s[7:6];
  wire [1:0] snk    = s[5:4];
  wire [1:0] fbr    = s[3:2];
  wire [1:0] fbf    = s[1:0];

  reg [1:0] tcfg_m_q;
  reg [1:0] tcfg_s_q;
  reg [1:0] tchg_q;
  reg [1:0] wdi_q;
  reg       wdi_last_q;

  // Timer pin and strobe are pins too, so they get two stages as well
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tcfg_m_q <= 2'h0;
      tcfg_s_q <= 2'h0;
      tchg_q <= 2'h0;
      wdi_q <= 2'h0;
      wdi_last_q <= 1'b0;
    end else begin
      tcfg_m_q <= i_timer_cfg;
      tcfg_s_q <= tcfg_m_q;
      tchg_q <= {tchg_q[0], i_timer_charged};
      wdi_q <= {wdi_q[0], i_watchdog_strobe_in};
      wdi_last_q <= wdi_q[1];
    end
  end

  // Enable with hysteresis: only a lower-threshold report turns it off
  reg en_q;
  always @(posedge i_core_clk) begin
    if (!i_rst_n)
      en_q <= 1'b0;
    else if (en_lo)
      en_q <= 1'b0;
    else if (en_hi)
      en_q <= 1'b1;
  end

  // Oscillator divider gives one-cycle tick per switching period
  reg [`BFR_OSC_W-1:0] osc_q;
  reg                  tick_q;
  always @(posedge i_core_clk) begin
    if (!i_rst_n || !en_q) begin
      osc_q <= {`BFR_OSC_W{1'b0}};
      tick_q <= 1'b0;
    end else if (osc_q == `BFR_OSC_DIV - 1) begin
      osc_q <= {`BFR_OSC_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      osc_q <= osc_q + {{(`BFR_OSC_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      bfr_channel bfr_channel_inst (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_run      (en_q),
        .i_osc_tick (tick_q),
        .i_peak_lim (pk[g]),
        .i_src_lim  (src[g]),
        .i_sink_lim (snk[g]),
        .o_hs_on    (hs_w[g]),
        .o_ls_on    (ls_w[g]),
        .o_ss_busy  (ssb_w[g]),
        .o_hiccup   (hic_w[g])
      );
    end
  endgenerate

  // Output-good latches: set above rising, clear below falling or while disabled
  reg [1:0] good_q;
  always @(posedge i_core_clk) begin
    if (!i_rst_n || !en_q)
      good_q <= 2'h0;
    else begin
      good_q[0] <= fbf[0] ? 1'b0 : (fbr[0] ? 1'b1 : good_q[0]);
      good_q[1] <= fbf[1] ? 1'b0 : (fbr[1] ? 1'b1 : good_q[1]);
    end
  end

  // Timer mode frozen at startup so a glitch cannot change it mid-run
  reg [1:0] mode_q;
  always @(posedge i_core_clk) begin
    if (!i_rst_n)
      mode_q <= `BFR_TMR_FLOAT;
    else if (!en_q)
      mode_q <= tcfg_s_q;
  end

  // Watchdog: arms on first rising strobe after reset release
  reg [`BFR_WD_W-1:0] wd_q;
  reg                 wd_arm_q;
  reg                 wd_fault_q;
  wire                wdi_edge = wdi_q[1] ^ wdi_last_q;
  wire                wdi_rise = wdi_q[1] & ~wdi_last_q;
  always @(posedge i_core_clk) begin
    if (!i_rst_n || !o_por_out) begin
      wd_q <= {`BFR_WD_W{1'b0}};
      wd_arm_q <= 1'b0;
      wd_fault_q <= 1'b0;
    end else if (!wd_arm_q) begin
      wd_q <= {`BFR_WD_W{1'b0}};
      if (wdi_rise) begin
        wd_arm_q <= 1'b1;
        wd_fault_q <= 1'b0;
      end
    end else if (wdi_edge) begin
      wd_q <= {`BFR_WD_W{1'b0}};
    end else if (wd_q == WD_TIMEOUT_CLK - 1) begin
      wd_fault_q <= 1'b1;
      wd_arm_q <= 1'b0;
    end else begin
      wd_q <= wd_q + {{(`BFR_WD_W-1){1'b0}}, 1'b1};
    end
  end

  // Release delay: internal count must end, and in cap modes the pin too
  reg [`BFR_DLY_W-1:0] dly_q;
  reg                  por_q;
  wire all_good  = &good_q;
  wire int_done  = (dly_q == POR_DELAY_CLK);
  wire ext_done  = (mode_q == `BFR_TMR_FLOAT) | tchg_q[1];
  wire wd_drop   = (mode_q == `BFR_TMR_RC) & wd_fault_q;
  always @(posedge i_core_clk) begin
    if (!i_rst_n || !all_good || wd_drop) begin
      dly_q <= {`BFR_DLY_W{1'b0}};
      por_q <= 1'b0;
    end else begin
      if (!int_done)
        dly_q <= dly_q + {{(`BFR_DLY_W-1){1'b0}}, 1'b1};
      if (int_done && ext_done)
        por_q <= 1'b1;
    end
  end

  // Registered outputs; open-drain lines drive low only when not good
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_hs_on <= 2'h0;
      o_ls_on <= 2'h0;
      o_enabled <= 1'b0;
      o_por_oe <= 1'b1;
      o_por_out <= 1'b0;
      o_watchdog_fault_oe <= 1'b1;
      o_watchdog_fault_out <= 1'b0;
    end else begin
      o_hs_on <= hs_w & {2{en_q}};
      o_ls_on <= ls_w & {2{en_q}};
      o_enabled <= en_q;
      o_por_oe <= ~por_q;
      o_por_out <= por_q;
      o_watchdog_fault_oe <= ~(wd_arm_q & ~wd_fault_q);
      o_watchdog_fault_out <= 1'b0;
    end
  end
endmodule // bfr_top

// ### verification/bfr_props.sv
// Checker for the sequencer top: gates, enable, reset-good and watchdog.
// Assumes a bind onto bfr_top with the same delay parameters.
`timescale 1ns/10ps
`include "bfr_regs.vh"
module bfr_props #(
  parameter [`BFR_DLY_W-1:0] POR_DELAY_CLK  = 23'h32,
  parameter [`BFR_WD_W-1:0]  WD_TIMEOUT_CLK = 23'h64
) (
  input wire       i_core_clk,
  input wire       i_rst_n,
  input wire       i_en_above_hi,
  input wire       i_en_below_lo,
  input wire [1:0] i_peak_lim,
  input wire [1:0] i_src_lim,
  input wire [1:0] i_sink_lim,
  input wire [1:0] i_fb_above_rise,
  input wire [1:0] i_fb_below_fall,
  input wire [1:0] i_timer_cfg,
  input wire       i_watchdog_strobe_in,
  input wire [1:0] o_hs_on,
  input wire [1:0] o_ls_on,
  input wire       o_enabled,
  input wire       o_por_oe,
  input wire       o_por_out,
  input wire       o_watchdog_fault_oe
);
  reg [22:0] good_q;
  reg [22:0] still_q;
  reg        strobe_q;
  // Saturating counts of good-output time and strobe idle time
  always @(posedge i_core_clk) begin
    strobe_q <= i_watchdog_strobe_in;
    if (!i_rst_n || !(&i_fb_above_rise)) good_q <= 23'h0;
    else if (good_q != 23'h7FFFFF) good_q <= good_q + 23'h1;
    if (!i_rst_n || strobe_q != i_watchdog_strobe_in) still_q <= 23'h0;
    else if (still_q != 23'h7FFFFF) still_q <= still_q + 23'h1;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  chk_no_overlap: assert property (!(|(o_hs_on & o_ls_on)))
    else $error("high and low side on together");
  chk_en_rise: assert property ($rose(i_en_above_hi) && !i_en_below_lo
    |-> ##[1:6] o_enabled) else $error("enable not taken");
  chk_en_fall: assert property ($rose(i_en_below_lo)
    |-> ##[1:6] !o_enabled) else $error("shutdown not taken");
  chk_gates_off: assert property (!o_enabled [*4]
    |-> o_hs_on == 2'h0 && o_ls_on == 2'h0) else $error("gates on in off");
  chk_peak_cut: assert property ($rose(i_peak_lim[0]) && o_hs_on[0]
    |-> ##[1:6] !o_hs_on[0]) else $error("peak trip ignored");
  chk_sink_cut: assert property ($rose(i_sink_lim[0]) && o_ls_on[0]
    |-> ##[1:6] !o_hs_on[0] && !o_ls_on[0]) else $error("sink trip ignored");
  chk_src_block: assert property ($rose(o_hs_on[0])
    |-> !$past(i_src_lim[0], 4)) else $error("high side on over source limit");
  chk_por_drop: assert property (!o_por_oe && (|i_fb_below_fall)
    |-> ##[1:5] o_por_oe) else $error("reset not asserted on low output");
  chk_por_delay: assert property ($fell(o_por_oe)
    |-> good_q >= POR_DELAY_CLK) else $error("reset released early");
  chk_por_level: assert property (o_por_oe |-> !o_por_out)
    else $error("reset line driven high");
  chk_rc_drop: assert property (i_timer_cfg == `BFR_TMR_RC
    && $rose(o_watchdog_fault_oe) |-> ##[0:4] o_por_oe)
    else $error("watchdog fault kept reset released");
  chk_wd_trip: assert property (still_q > WD_TIMEOUT_CLK + 8
    |-> o_watchdog_fault_oe) else $error("watchdog timeout missed");
endmodule // bfr_props
bind bfr_top bfr_props #(
  .POR_DELAY_CLK(POR_DELAY_CLK),
  .WD_TIMEOUT_CLK(WD_TIMEOUT_CLK)
) bfr_props_inst (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_en_above_hi(i_en_above_hi), .i_en_below_lo(i_en_below_lo),
  .i_peak_lim(i_peak_lim), .i_src_lim(i_src_lim), .i_sink_lim(i_sink_lim),
  .i_fb_above_rise(i_fb_above_rise), .i_fb_below_fall(i_fb_below_fall),
  .i_timer_cfg(i_timer_cfg), .i_watchdog_strobe_in(i_watchdog_strobe_in),
  .o_hs_on(o_hs_on), .o_ls_on(o_ls_on), .o_enabled(o_enabled),
  .o_por_oe(o_por_oe), .o_por_out(o_por_out),
  .o_watchdog_fault_oe(o_watchdog_fault_oe)
);

// ### verification/bfr_stage_model.sv
// Power stage stand-in: channel 0 peak comparator under a heavy load.
// Assumes registered gate commands from the block; channel 1 never trips.
`timescale 1ns/10ps
module bfr_stage_model (
  input  wire       i_core_clk,
  input  wire [1:0] i_hs_on,
  input  wire       i_heavy,
  output reg  [1:0] o_peak_lim
);
  reg [4:0] on_q = 5'h0;
  initial o_peak_lim = 2'h0;
  // Trips after 20 cycles of conduction, drops once the switch opens;
  // the count saturates so a long on-time cannot wrap below the trip
  always @(posedge i_core_clk) begin
    if (!i_hs_on[0]) on_q <= 5'h0;
    else if (on_q != 5'h1F) on_q <= on_q + 5'h1;
    o_peak_lim <= {1'b0, i_heavy && i_hs_on[0] && on_q >= 5'h14};
  end
endmodule // bfr_stage_model

// ### verification/bfr_tb.sv
// Self-checking bench for the sequencer top with a power stage model.
// Assumes short reset and watchdog delays set by parameter below.
`timescale 1ns/10ps
`include "bfr_regs.vh"
module buck_fault_and_reset_sequencer_test;
  reg        clk = 1'b0, rst_n = 1'b0, en_hi = 1'b0, en_lo = 1'b1;
  reg        heavy = 1'b0, charged = 1'b0, strobe = 1'b0, seen = 1'b0;
  reg  [1:0] src = 2'h0, sink = 2'h0, rise = 2'h0, fall = 2'h3, cfg = 2'h2;
  wire [1:0] peak, hs, ls;
  wire       enabled, por_oe, por_out, wd_oe, wd_out;
  integer    fail_count = 0, num_checks = 0, i;
  always #5 clk = ~clk;
  bfr_stage_model bfr_stage_model_inst (.i_core_clk(clk), .i_hs_on(hs),
    .i_heavy(heavy), .o_peak_lim(peak));
  bfr_top #(.POR_DELAY_CLK(23'h32), .WD_TIMEOUT_CLK(23'h64)) bfr_top_inst (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_en_above_hi(en_hi),
    .i_en_below_lo(en_lo), .i_peak_lim(peak), .i_src_lim(src),
    .i_sink_lim(sink), .i_fb_above_rise(rise), .i_fb_below_fall(fall),
    .i_timer_cfg(cfg), .i_timer_charged(charged),
    .i_watchdog_strobe_in(strobe), .o_hs_on(hs), .o_ls_on(ls),
    .o_enabled(enabled), .o_por_oe(por_oe), .o_por_out(por_out),
    .o_watchdog_fault_oe(wd_oe), .o_watchdog_fault_out(wd_out));
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task check(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, got, exp);
      end
    end
  endtask
  // A bounded wait that ran out ends the run at once
  task must(input ok);
    begin
      check(ok, 1'b1);
      if (ok !== 1'b1) tally_and_finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Timer mode only changes while held in reset, as the block latches it
  task do_reset(input [1:0] c);
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      cfg <= c;
      {en_hi, en_lo, src, sink, rise, fall} <= 10'h203;
      charged <= (c == `BFR_TMR_RC);
      cyc(3);
      rst_n <= 1'b1;
    end
  endtask
  task t_switch;
    begin
      for (i = 0; i < 400 && hs[0] !== 1'b1; i = i + 1) cyc(1);
      check(enabled, 1'b1);
      must(hs[0] === 1'b1);
      cyc(100);
      check({hs[0], ls[0]}, 2'h2);
      heavy <= 1'b1;
      for (i = 0; i < 20 && hs[0] !== 1'b0; i = i + 1) cyc(1);
      heavy <= 1'b0;
      check({hs[0], ls[0]}, 2'h1);
      sink <= 2'h1;
      cyc(6);
      check({hs[0], ls[0]}, 2'h0);
      sink <= 2'h0;
      for (i = 0; i < 340 && hs[0] !== 1'b1; i = i + 1) cyc(1);
      must(hs[0] === 1'b1);
      en_lo <= 1'b1;
      en_hi <= 1'b0;
      cyc(8);
      check({enabled, hs, ls}, 5'h0);
      $display("switching and shutdown test done");
    end
  endtask
  // Source limit held: high side stays off, then hiccup opens both
  task t_hiccup;
    begin
      src <= 2'h1;
      cyc(340);
      for (i = 0; i < 1600; i = i + 1) begin
        cyc(1);
        if (hs[0] !== 1'b0) seen = 1'b1;
      end
      check(seen, 1'b0);
      check(ls[0], 1'b1);
      seen = 1'b0;
      cyc(2100);
      for (i = 0; i < 500; i = i + 1) begin
        cyc(1);
        if ({hs[0], ls[0]} !== 2'h0) seen = 1'b1;
      end
      check(seen, 1'b0);
      $display("hiccup test done");
    end
  endtask
  task t_por_float;
    begin
      do_reset(`BFR_TMR_FLOAT);
      {rise, fall} <= 4'hC;
      cyc(30);
      check(por_oe, 1'b1);
      cyc(40);
      check({por_oe, por_out & por_oe}, 2'h0);
      {rise, fall} <= 4'h6;
      cyc(6);
      check(por_oe, 1'b1);
      $display("floating timer test done");
    end
  endtask
  task t_por_cap;
    begin
      do_reset(`BFR_TMR_CAP);
      {rise, fall} <= 4'hC;
      cyc(120);
      check(por_oe, 1'b1);
      charged <= 1'b1;
      cyc(6);
      check(por_oe, 1'b0);
      {rise, fall} <= 4'h9;
      cyc(6);
      check(por_oe, 1'b1);
      $display("capacitor timer test done");
    end
  endtask
  task t_por_rc;
    begin
      do_reset(`BFR_TMR_RC);
      {rise, fall} <= 4'hC;
      cyc(70);
      check({por_oe, wd_oe}, 2'h1);
      strobe <= 1'b1;
      cyc(6);
      check(wd_oe, 1'b0);
      cyc(150);
      check({por_oe, wd_oe}, 2'h3);
      check(wd_out, 1'b0);
      $display("watchdog test done");
    end
  endtask
  initial begin
    do_reset(`BFR_TMR_FLOAT);
    t_switch;
    do_reset(`BFR_TMR_FLOAT);
    t_hiccup;
    t_por_float;
    t_por_cap;
    t_por_rc;
    tally_and_finish;
  end
endmodule // buck_fault_and_reset_sequencer_test
